//--- logic/mtm_map.svh
// constants for the multichannel temperature monitor: codes, limits, timing
// assumes integer degrees celsius, signed 10-bit values, 10 MHz clock
`ifndef MTM_MAP_SVH
`define MTM_MAP_SVH
`define MTM_NUM_CH 12
`define MTM_NUM_BLK 6
`define MTM_NUM_GRP 3
`define MTM_SENS_OFF 3'h0
`define MTM_SENS_PTC 3'h1
`define MTM_SENS_SILICON 3'h2
`define MTM_SENS_BIMETAL 3'h4
`define MTM_SENS_PT100 3'h5
`define MTM_SENS_PT1000 3'h6
`define MTM_WIRE_2W 2'h0
`define MTM_WIRE_DUAL_2W 2'h1
`define MTM_WIRE_3W 2'h2
`define MTM_WIRE_4W 2'h3
`define MTM_SW_LOW (-10'sd50)
`define MTM_SW_HIGH (10'sd250)
`define MTM_THR_MIN (-10'sd99)
`define MTM_THR_MAX (10'sd251)
`define MTM_THR_OFF (10'sd251)
`define MTM_FAIL_VALUE (-10'sd300)
`define MTM_CH_SPACING 6
// last tick index and divisor of one line period of samples
`define MTM_LINE_LAST_50 3'h4
`define MTM_LINE_LAST_60 3'h5
`define MTM_LINE_DIV_50 14'sd5
`define MTM_LINE_DIV_60 14'sd6
// clock period in ns and one millisecond expressed in cycles
`define MTM_CLK_PERIOD_NS 100
`define MTM_MS_NS 1000000
`define MTM_MS_CYCLES (`MTM_MS_NS / `MTM_CLK_PERIOD_NS)
// raw sensor code per unit of cable resistance (ohm) subtracted before use
`define MTM_CABLE_SHIFT 0
`endif

//--- logic/mtm_pkg.sv
// types for the multichannel temperature monitor
// assumes mtm_map.svh is on the include path
`include "mtm_map.svh"
package mtm_pkg;
  typedef logic signed [9:0] mtm_temp_t;
  typedef logic [2:0] mtm_sens_t;
  typedef logic [1:0] mtm_wire_t;
  typedef logic [11:0] mtm_mask_t;
endpackage : mtm_pkg

//--- logic/mtm_group_calc.sv
// one group: max, min and average over member channel values
// assumes inputs stable while start pulses; answer one cycle later
module mtm_group_calc
  import mtm_pkg::*;
#(
  parameter int NUM_CH = 12
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic start,
  input wire mtm_pkg::mtm_mask_t member,
  input wire logic [NUM_CH-1:0] ch_valid,
  input wire logic [NUM_CH-1:0] ch_failed,
  input wire logic [NUM_CH*10-1:0] ch_values,
  input wire logic fail_response,
  output mtm_pkg::mtm_temp_t grp_max,
  output mtm_pkg::mtm_temp_t grp_min,
  output mtm_pkg::mtm_temp_t grp_avg
);
  import mtm_pkg::*;
  mtm_temp_t next_max, next_min, next_avg;
  always_comb begin
    logic signed [15:0] sum;
    logic [4:0] cnt;
    logic any_fail;
    mtm_temp_t v;
    sum = '0;
    cnt = '0;
    any_fail = 1'b0;
    v = '0;
    next_max = grp_max;
    next_min = grp_min;
    next_avg = grp_avg;
    if (start) begin
      next_max = 10'sh200;
      next_min = 10'sd511;
      for (int i = 0; i < NUM_CH; i++) begin
        v = mtm_temp_t'(ch_values[i*10 +: 10]);
        if (member[i] && ch_failed[i]) begin
          any_fail = 1'b1;
        end else if (member[i] && ch_valid[i]) begin
          sum = sum + 16'(v);
          cnt = cnt + 5'h1;
          if (v > next_max) next_max = v;
          if (v < next_min) next_min = v;
        end
      end
      if (cnt != 5'h0) begin
        next_avg = mtm_temp_t'(sum / $signed({11'h0, cnt}));
      end else begin
        next_max = '0;
        next_min = '0;
        next_avg = '0;
      end
      if (fail_response && any_fail) begin
        next_max = `MTM_FAIL_VALUE;
        next_min = `MTM_FAIL_VALUE;
        next_avg = `MTM_FAIL_VALUE;
      end
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      grp_max <= '0;
      grp_min <= '0;
      grp_avg <= '0;
    end else begin
      grp_max <= next_max;
      grp_min <= next_min;
      grp_avg <= next_avg;
    end
  end
endmodule : mtm_group_calc

//--- logic/mtm_monitor.sv
// twelve-channel temperature evaluation: thresholds, timers, groups
// assumes raw sensor codes arrive from a front end on the same clock
`include "mtm_map.svh"
// Notes on behaviour
// - type codes: 0 off,1 ptc,2 silicon,4 bimetal,5 pt100,6 pt1000
// - switching sensors report -50 below, +250 above response point
// - twelve channels, each enabled by an active type code; 6..11 only in dual two-wire blocks
// - thresholds accepted from -99 to +251 degrees
// - a threshold of 251 disables that comparison
// - entry 2x is warning, entry 2x+1 is fault threshold
// - value above warning sets alarm and starts delay timer
// - alarm holds until value at or below warning minus hysteresis
// - still above warning when timer expires raises fault
// - value above fault threshold raises fault at once
// - fault clears only on acknowledge, after hysteresis drop unless the fault threshold is 251
// - three groups with mask, giving max, min and average
// - fail response 0 excludes failed sensor, 1 forces -300
// - six blocks with wiring code 0..3
// - dual two-wire second sensor lands on channel plus six
// - request flag starts cable measurement, done pulses when stored
// - stored cable resistance compensates every evaluation except of switching sensors
// - line filter selectable between 50 and 60 Hz
// - optional first-order smoothing, effective time reported
module mtm_monitor
  import mtm_pkg::*;
#(
  parameter int NUM_CH = `MTM_NUM_CH,
  parameter int TIMER_W = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sample_tick,
  input wire logic [NUM_CH*10-1:0] raw_value,
  input wire logic [NUM_CH-1:0] sensor_open,
  input wire logic [NUM_CH*3-1:0] sensor_type_sel,
  input wire logic [`MTM_NUM_BLK*2-1:0] block_wiring_method,
  input wire logic [2*NUM_CH*10-1:0] channel_threshold_array,
  input wire logic [NUM_CH*8-1:0] threshold_hysteresis,
  input wire logic [NUM_CH*TIMER_W-1:0] alarm_delay_timer,
  input wire logic [NUM_CH-1:0] cable_meas_request,
  input wire logic [NUM_CH-1:0] cable_write,
  input wire logic [NUM_CH*8-1:0] cable_write_value,
  input wire logic [NUM_CH-1:0] smoothing_enable,
  input wire logic [NUM_CH*4-1:0] smoothing_time_const,
  input wire logic line_freq_select,
  input wire logic [NUM_CH-1:0] fault_ack,
  input wire logic [`MTM_NUM_GRP*12-1:0] group_channel_mask,
  input wire logic [`MTM_NUM_GRP-1:0] group_fail_response,
  output logic [NUM_CH*10-1:0] channel_temp_value,
  output logic [2*NUM_CH-1:0] eval_status_bits,
  output logic [NUM_CH-1:0] cable_meas_done,
  output logic [NUM_CH*8-1:0] cable_resistance_value,
  output logic [NUM_CH*8-1:0] smoothing_time_effective,
  output logic [`MTM_NUM_GRP*10-1:0] group_max_value,
  output logic [`MTM_NUM_GRP*10-1:0] group_min_value,
  output logic [`MTM_NUM_GRP*10-1:0] group_avg_value
);
  import mtm_pkg::*;
  if (NUM_CH != 12 || TIMER_W < 1 || TIMER_W > 24) begin : g_bad_param
    $error("mtm_monitor: unsupported parameters");
  end

  function automatic logic is_switching(input mtm_sens_t t);
    return t == `MTM_SENS_PTC || t == `MTM_SENS_BIMETAL;
  endfunction : is_switching

  function automatic logic is_active(input mtm_sens_t t);
    return t == `MTM_SENS_PTC || t == `MTM_SENS_SILICON ||
      t == `MTM_SENS_BIMETAL || t == `MTM_SENS_PT100 ||
      t == `MTM_SENS_PT1000;
  endfunction : is_active

  function automatic mtm_temp_t clamp_thr(input mtm_temp_t t);
    if (t < `MTM_THR_MIN) return `MTM_THR_MIN;
    if (t > `MTM_THR_MAX) return `MTM_THR_MAX;
    return t;
  endfunction : clamp_thr

  // channel is wired when its block uses a mode that serves it
  function automatic logic ch_wired(input int ch, input mtm_wire_t m);
    if (ch < `MTM_CH_SPACING) return 1'b1;
    return m == `MTM_WIRE_DUAL_2W;
  endfunction : ch_wired

  // 50/60 Hz filter: average over one line period of sample ticks
  logic [NUM_CH-1:0] ch_valid;
  logic [NUM_CH-1:0] ch_failed;
  logic [2:0] line_cnt, next_line_cnt;
  logic line_done;
  assign line_done = sample_tick && (line_cnt == (line_freq_select ?
    `MTM_LINE_LAST_60 : `MTM_LINE_LAST_50));

  mtm_temp_t value [NUM_CH];
  mtm_temp_t next_value [NUM_CH];
  logic signed [13:0] acc [NUM_CH];
  logic signed [13:0] next_acc [NUM_CH];
  logic [7:0] cable [NUM_CH];
  logic [7:0] next_cable [NUM_CH];
  logic [NUM_CH-1:0] alarm, next_alarm, fault, next_fault;
  logic [NUM_CH-1:0] timing, next_timing, done, next_done;
  logic [TIMER_W-1:0] tmr [NUM_CH];
  logic [TIMER_W-1:0] next_tmr [NUM_CH];
  logic grp_start, next_grp_start;

  // channel enables settle before the evaluation loop reads them
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      ch_valid[i] = is_active(mtm_sens_t'(sensor_type_sel[i*3 +: 3])) &&
        ch_wired(i, mtm_wire_t'(
        block_wiring_method[(i % `MTM_NUM_BLK)*2 +: 2]));
      ch_failed[i] = ch_valid[i] && sensor_open[i];
    end
  end

  always_comb begin
    mtm_temp_t raw, filt, warn, flt, hys, comp;
    mtm_sens_t typ;
    logic signed [13:0] diff;
    raw = '0;
    filt = '0;
    warn = '0;
    flt = '0;
    hys = '0;
    comp = '0;
    typ = '0;
    diff = '0;
    next_line_cnt = line_cnt;
    if (sample_tick) next_line_cnt = line_done ? 3'h0 : line_cnt + 3'h1;
    next_grp_start = line_done;
    for (int i = 0; i < NUM_CH; i++) begin
      typ = mtm_sens_t'(sensor_type_sel[i*3 +: 3]);
      raw = mtm_temp_t'(raw_value[i*10 +: 10]);
      next_value[i] = value[i];
      next_acc[i] = acc[i];
      next_cable[i] = cable[i];
      next_done[i] = 1'b0;
      if (cable_write[i]) next_cable[i] = cable_write_value[i*8 +: 8];
      if (cable_meas_request[i] && sample_tick && ch_valid[i]) begin
        next_cable[i] = raw[7:0];
        next_done[i] = 1'b1;
      end
      comp = raw - mtm_temp_t'({2'b00, cable[i]});
      if (sample_tick && ch_valid[i] && !cable_meas_request[i]) begin
        next_acc[i] = line_done ? 14'sd0 : acc[i] + 14'(comp);
        if (line_done) begin
          filt = mtm_temp_t'((acc[i] + 14'(comp)) / (line_freq_select ?
            `MTM_LINE_DIV_60 : `MTM_LINE_DIV_50));
          if (is_switching(typ)) begin
            filt = raw[0] ? `MTM_SW_HIGH : `MTM_SW_LOW;
          end
          if (smoothing_enable[i] && !is_switching(typ)) begin
            diff = 14'(filt) - 14'(value[i]);
            next_value[i] = value[i] +
              mtm_temp_t'(diff >>> smoothing_time_const[i*4 +: 4]);
          end else begin
            next_value[i] = filt;
          end
        end
      end else if (!ch_valid[i]) begin
        next_value[i] = '0;
      end
      // effective smoothing time scales with active channel count
      smoothing_time_effective[i*8 +: 8] = smoothing_enable[i] ?
        8'((8'h1 << smoothing_time_const[i*4 +: 4]) *
        8'($countones(ch_valid))) : 8'h0;
      warn = clamp_thr(mtm_temp_t'(channel_threshold_array[20*i +: 10]));
      flt = clamp_thr(
        mtm_temp_t'(channel_threshold_array[20*i+10 +: 10]));
      hys = mtm_temp_t'({2'b00, threshold_hysteresis[i*8 +: 8]});
      next_alarm[i] = alarm[i];
      next_fault[i] = fault[i];
      next_timing[i] = timing[i];
      next_tmr[i] = tmr[i];
      if (warn == `MTM_THR_OFF || !ch_valid[i]) begin
        next_alarm[i] = 1'b0;
        next_timing[i] = 1'b0;
      end else if (value[i] > warn && !alarm[i]) begin
        next_alarm[i] = 1'b1;
        next_timing[i] = 1'b1;
        next_tmr[i] = alarm_delay_timer[i*TIMER_W +: TIMER_W];
      end else if (alarm[i] && value[i] <= warn - hys) begin
        next_alarm[i] = 1'b0;
        next_timing[i] = 1'b0;
      end
      if (fault[i] && fault_ack[i] && (flt == `MTM_THR_OFF ||
          value[i] <= flt - hys)) begin
        next_fault[i] = 1'b0;
      end
      // raising paths come after the clear so a set wins the same cycle
      if (timing[i] && alarm[i]) begin
        if (tmr[i] == '0) begin
          next_timing[i] = 1'b0;
          if (value[i] > warn) next_fault[i] = 1'b1;
        end else begin
          next_tmr[i] = tmr[i] - TIMER_W'(1);
        end
      end
      if (flt != `MTM_THR_OFF && ch_valid[i] && value[i] > flt) begin
        next_fault[i] = 1'b1;
      end
      channel_temp_value[i*10 +: 10] = value[i];
      eval_status_bits[2*i] = alarm[i];
      eval_status_bits[2*i+1] = fault[i];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      line_cnt <= 3'h0;
      grp_start <= 1'b0;
      alarm <= '0;
      fault <= '0;
      timing <= '0;
      done <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        value[i] <= '0;
        acc[i] <= '0;
        cable[i] <= '0;
        tmr[i] <= '0;
      end
    end else begin
      line_cnt <= next_line_cnt;
      grp_start <= next_grp_start;
      alarm <= next_alarm;
      fault <= next_fault;
      timing <= next_timing;
      done <= next_done;
      for (int i = 0; i < NUM_CH; i++) begin
        value[i] <= next_value[i];
        acc[i] <= next_acc[i];
        cable[i] <= next_cable[i];
        tmr[i] <= next_tmr[i];
      end
    end
  end

  always_comb begin
    cable_meas_done = done;
    for (int i = 0; i < NUM_CH; i++) begin
      cable_resistance_value[i*8 +: 8] = cable[i];
    end
  end

  for (genvar g = 0; g < `MTM_NUM_GRP; g++) begin : g_grp
    mtm_group_calc #(.NUM_CH(NUM_CH)) u_grp (
      .clk(clk),
      .arst_n(arst_n),
      .start(grp_start),
      .member(group_channel_mask[g*12 +: 12]),
      .ch_valid(ch_valid),
      .ch_failed(ch_failed),
      .ch_values(channel_temp_value),
      .fail_response(group_fail_response[g]),
      .grp_max(group_max_value[g*10 +: 10]),
      .grp_min(group_min_value[g*10 +: 10]),
      .grp_avg(group_avg_value[g*10 +: 10])
    );
  end

  a_fault_imm: assert property (
    @(posedge clk) disable iff (!arst_n)
    (ch_valid[3] && clamp_thr(mtm_temp_t'(channel_threshold_array[79:70]))
    != `MTM_THR_OFF && value[3] > clamp_thr(
    mtm_temp_t'(channel_threshold_array[79:70]))) |=> fault[3])
    else $error("fault not raised above fault threshold");
  a_alarm_set: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(alarm[2]) |-> timing[2] &&
    tmr[2] == $past(alarm_delay_timer[2*TIMER_W +: TIMER_W]))
    else $error("alarm set without timer start");
  a_timer_fault: assert property (
    @(posedge clk) disable iff (!arst_n)
    (timing[2] && alarm[2] && tmr[2] == '0 && value[2] >
    clamp_thr(mtm_temp_t'(channel_threshold_array[49:40]))) |=> fault[2])
    else $error("fault not raised when delay timer expired");
  a_fault_hold: assert property (
    @(posedge clk) disable iff (!arst_n)
    $fell(fault[3]) |-> $past(fault_ack[3]))
    else $error("fault cleared without acknowledge");
  a_meas_done: assert property (
    @(posedge clk) disable iff (!arst_n)
    done[5] |-> cable[5] == $past(raw_value[57:50]))
    else $error("cable value not stored on completion");
  a_thr_off: assert property (
    @(posedge clk) disable iff (!arst_n)
    mtm_temp_t'(channel_threshold_array[9:0]) == `MTM_THR_OFF
    |=> !alarm[0])
    else $error("disabled warning threshold raised alarm");
  a_grp_once: assert property (
    @(posedge clk) disable iff (!arst_n)
    grp_start |=> !grp_start)
    else $error("group start longer than one cycle");
  a_alarm_clr: assert property (
    @(posedge clk) disable iff (!arst_n)
    $fell(alarm[2]) && ch_valid[2] && clamp_thr(mtm_temp_t'(
    channel_threshold_array[49:40])) != `MTM_THR_OFF |-> $past(value[2]) <=
    $past(clamp_thr(mtm_temp_t'(channel_threshold_array[49:40])) -
    mtm_temp_t'({2'b00, threshold_hysteresis[23:16]})))
    else $error("alarm cleared above hysteresis band");
  a_sw_value: assert property (
    @(posedge clk) disable iff (!arst_n)
    (line_done && ch_valid[0] && !cable_meas_request[0] &&
    is_switching(mtm_sens_t'(sensor_type_sel[2:0]))) |=>
    value[0] == ($past(raw_value[0]) ? `MTM_SW_HIGH : `MTM_SW_LOW))
    else $error("switching channel shows no symbolic value");
  a_unwired: assert property (
    @(posedge clk) disable iff (!arst_n)
    block_wiring_method[1:0] != `MTM_WIRE_DUAL_2W |-> !ch_valid[6])
    else $error("channel 6 valid without dual two-wire block");
endmodule : mtm_monitor

//--- bench/mtm_sensor_model.sv
// sensor front end model: turns per-channel settings into raw codes
// assumes the bench changes its settings at the falling clock edge
module mtm_sensor_model #(
  parameter int TICK_GAP = 4,
  parameter int SHORT_CODE = 7
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [119:0] temp_set,
  input wire logic [11:0] open_set,
  input wire logic [11:0] shorted,
  output logic sample_tick,
  output logic [119:0] raw_value,
  output logic [11:0] sensor_open
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      sample_tick <= 1'b0;
      raw_value <= '0;
    end else if (cnt == TICK_GAP - 1) begin
      cnt <= 0;
      sample_tick <= 1'b1;
      for (int i = 0; i < 12; i++) begin
        // a jumpered sensor shows only its cable
        raw_value[i*10 +: 10] <= shorted[i] ? 10'(SHORT_CODE) :
                                 temp_set[i*10 +: 10];
      end
    end else begin
      cnt <= cnt + 1;
      sample_tick <= 1'b0;
      // code is only valid with the tick
      raw_value <= ~raw_value;
    end
  end
  assign sensor_open = open_set;
endmodule : mtm_sensor_model

//--- bench/tb_mtm_monitor.sv
// self-checking bench for the temperature monitor
// assumes the sensor model ticks every four cycles
module tb_mtm_monitor;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [2:0] ty; logic [9:0] raw; logic [9:0] ex;}
    mtm_row_t;
  logic clk, arst_n, tick, lfs;
  logic [119:0] raw, temp, cv;
  logic [11:0] op, sh, req, cw, smo, ack, done;
  logic [35:0] typ, mask;
  logic [11:0] wire_m;
  logic [239:0] thr;
  logic [95:0] hy, cwv;
  logic [191:0] dly;
  logic [47:0] stc;
  logic [2:0] gfr;
  logic [23:0] st;
  logic [95:0] cres;
  logic [95:0] ste;
  logic [11:0] sop;
  logic [29:0] gmax, gmin, gavg;
  int n_mismatch = 0;
  int n_tests = 0;
  mtm_row_t rows [9] = '{
    '{3'h0, 10'h020, 10'h000}, '{3'h1, 10'h003, 10'h0fa},
    '{3'h1, 10'h002, 10'h3ce}, '{3'h2, 10'h025, 10'h025},
    '{3'h3, 10'h025, 10'h000}, '{3'h4, 10'h001, 10'h0fa},
    '{3'h5, 10'h3ec, 10'h3ec}, '{3'h6, 10'h0fb, 10'h0fb},
    '{3'h7, 10'h025, 10'h000}};
  mtm_sensor_model u_mtm_sensor_model (.clk(clk), .arst_n(arst_n),
    .temp_set(temp), .open_set(op), .shorted(sh), .sample_tick(tick),
    .raw_value(raw), .sensor_open(sop));
  mtm_monitor u_mtm_monitor (.clk(clk), .arst_n(arst_n), .sample_tick(tick),
    .raw_value(raw), .sensor_open(sop), .sensor_type_sel(typ),
    .block_wiring_method(wire_m), .channel_threshold_array(thr),
    .threshold_hysteresis(hy), .alarm_delay_timer(dly),
    .cable_meas_request(req), .cable_write(cw), .cable_write_value(cwv),
    .smoothing_enable(smo), .smoothing_time_const(stc),
    .line_freq_select(lfs), .fault_ack(ack), .group_channel_mask(mask),
    .group_fail_response(gfr), .channel_temp_value(cv),
    .eval_status_bits(st), .cable_meas_done(done),
    .cable_resistance_value(cres), .smoothing_time_effective(ste),
    .group_max_value(gmax), .group_min_value(gmin),
    .group_avg_value(gavg));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [9:0] ch(input int i);
    return cv[i*10 +: 10];
  endfunction : ch
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [9:0] e,
                     input logic [9:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic lost(input string nm);
    n_mismatch++;
    $display("[ERR] %s expected event seen none", nm);
    conclude();
  endtask : lost
  task automatic run(input int n);
    int seen;
    int guard;
    seen = 0;
    guard = 0;
    while (seen < n && guard < 1000) begin
      @(negedge clk);
      guard++;
      if (tick === 1'b1) seen++;
    end
    if (seen < n) lost("tick");
    repeat (3) @(negedge clk);
  endtask : run
  task automatic wait_st(input int b);
    int guard;
    guard = 0;
    while (st[b] !== 1'b1 && guard < 300) begin
      @(negedge clk);
      guard++;
    end
    if (st[b] !== 1'b1) lost("status");
  endtask : wait_st
  initial begin
    arst_n = 1'b0;
    {lfs, temp, op, sh, req, cw, smo, ack, mask, hy, cwv, stc, gfr} = '0;
    for (int i = 0; i < 12; i++) begin
      typ[i*3 +: 3] = 3'h2;
      dly[i*16 +: 16] = 16'h00ff;
      thr[i*20 +: 20] = {10'h0fb, 10'h0fb};
    end
    wire_m = 12'h555;
    repeat (5) @(negedge clk);
    chk("rst value", 10'h000, ch(0));
    chk("rst flags", 10'h000, st[9:0]);
    arst_n = 1'b1;
    $display("test reset done");
    for (int r = 0; r < 9; r++) begin
      for (int i = 0; i < 12; i++) begin
        typ[i*3 +: 3] = rows[r].ty;
        temp[i*10 +: 10] = rows[r].raw;
      end
      run(11);
      chk("ch0", rows[r].ex, ch(0));
      chk("ch11", rows[r].ex, ch(11));
      chk("flags", 10'h000, st[9:0]);
    end
    $display("test types done");
    typ = {12{3'h2}};
    temp = {12{10'h01e}};
    wire_m = 12'h5e4;
    run(11);
    chk("ch3", 10'h01e, ch(3));
    chk("ch6", 10'h000, ch(6));
    chk("ch7", 10'h01e, ch(7));
    chk("ch8", 10'h000, ch(8));
    chk("ch9", 10'h000, ch(9));
    wire_m = 12'h555;
    $display("test wiring done");
    thr[4*10 +: 10] = 10'h028;
    hy[2*8 +: 8] = 8'h05;
    dly[2*16 +: 16] = 16'h000a;
    temp[2*10 +: 10] = 10'h02d;
    wait_st(4);
    chk("fault2 early", 10'h000, st[5]);
    repeat (12) @(negedge clk);
    chk("fault2 timer", 10'h001, st[5]);
    temp[2*10 +: 10] = 10'h026;
    run(11);
    chk("alarm2 band", 10'h001, st[4]);
    temp[2*10 +: 10] = 10'h023;
    run(11);
    chk("alarm2 off", 10'h000, st[4]);
    $display("test alarm done");
    thr[7*10 +: 10] = 10'h03c;
    hy[3*8 +: 8] = 8'h05;
    temp[3*10 +: 10] = 10'h041;
    wait_st(7);
    chk("ch3 at fault", 10'h041, ch(3));
    chk("alarm3", 10'h000, st[6]);
    temp[3*10 +: 10] = 10'h039;
    ack[3] = 1'b1;
    run(11);
    chk("fault3 acked", 10'h001, st[7]);
    ack[3] = 1'b0;
    temp[3*10 +: 10] = 10'h037;
    run(11);
    chk("fault3 no ack", 10'h001, st[7]);
    ack[3] = 1'b1;
    repeat (3) @(negedge clk);
    chk("fault3 clear", 10'h000, st[7]);
    ack[3] = 1'b0;
    $display("test fault done");
    // continuous sensors only in groups
    temp[0 +: 40] = {10'h014, 10'h021, 10'h014, 10'h00a};
    temp[4*10 +: 10] = 10'h050;
    op[4] = 1'b1;
    mask = {12'h012, 12'h012, 12'h007};
    gfr = 3'h4;
    run(11);
    chk("g0 max", 10'h021, gmax[9:0]);
    chk("g0 min", 10'h00a, gmin[9:0]);
    chk("g0 avg", 10'h015, gavg[9:0]);
    chk("g1 max", 10'h014, gmax[19:10]);
    chk("g1 avg", 10'h014, gavg[19:10]);
    chk("g2 max", 10'h2d4, gmax[29:20]);
    chk("g2 min", 10'h2d4, gmin[29:20]);
    chk("g2 avg", 10'h2d4, gavg[29:20]);
    op[4] = 1'b0;
    $display("test groups done");
    sh[5] = 1'b1;
    // let one tick pass so the next latched code is the shorted cable
    run(1);
    req[5] = 1'b1;
    for (int k = 0; k < 300 && done[5] !== 1'b1; k++) @(negedge clk);
    if (done[5] !== 1'b1) lost("cable done");
    req[5] = 1'b0;
    chk("cable5", 10'h007, cres[5*8 +: 8]);
    sh[5] = 1'b0;
    temp[5*10 +: 10] = 10'h032;
    run(11);
    chk("ch5 comp", 10'h02b, ch(5));
    cw[5] = 1'b1;
    cwv[5*8 +: 8] = 8'h03;
    @(negedge clk);
    cw[5] = 1'b0;
    run(11);
    chk("cable5 wr", 10'h003, cres[5*8 +: 8]);
    chk("ch5 wr", 10'h02f, ch(5));
    $display("test cable done");
    lfs = 1'b1;
    temp[0 +: 10] = 10'h04d;
    run(13);
    chk("ch0 60hz", 10'h04d, ch(0));
    $display("test line done");
    smo[0] = 1'b1;
    stc[3:0] = 4'h1;
    temp[0 +: 10] = 10'h05d;
    @(negedge clk);
    chk("ste0", 10'h018, ste[7:0]);
    chk("ste1", 10'h000, ste[15:8]);
    // halving steps from 77 toward 93 settle one below the target
    run(37);
    chk("ch0 smooth", 10'h05c, ch(0));
    $display("test smoothing done");
    temp[1*10 +: 10] = 10'h392;
    thr[2*10 +: 10] = 10'h380;
    run(13);
    chk("alarm1 clamp", 10'h000, st[2]);
    $display("test clamp done");
    arst_n = 1'b0;
    @(negedge clk);
    chk("rst2 value", 10'h000, ch(0));
    chk("rst2 flags", 10'h000, st[9:0]);
    arst_n = 1'b1;
    $display("test rerun reset done");
    conclude();
  end
endmodule : tb_mtm_monitor
